// *** logic/load_switch_pkg.sv ***
// shared constants for the load switch protection controller
package load_switch_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned FAULT_DLY_MS    = 32;   // fault qualify/release, plain variant
    localparam int unsigned SURGE_WIN_MS    = 128;  // surge window and its release hold
    localparam int unsigned SAG_QUAL_MS     = 32;   // sag must persist this long
    localparam int unsigned SAG_RETRY_MS    = 128;  // off time after a sag disable
    localparam int unsigned RAMP_US         = 1000; // gate ramp duration

    // least times truncate to whole cycles
    localparam int unsigned FAULT_DLY_CYC   = (FAULT_DLY_MS * (CLK_HZ / 1000));
    localparam int unsigned SURGE_WIN_CYC   = (SURGE_WIN_MS * (CLK_HZ / 1000));
    localparam int unsigned SAG_QUAL_CYC    = (SAG_QUAL_MS * (CLK_HZ / 1000));
    localparam int unsigned SAG_RETRY_CYC   = (SAG_RETRY_MS * (CLK_HZ / 1000));
    localparam int unsigned RAMP_CYC        = (RAMP_US * (CLK_HZ / 1000000));

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned TMR_W           = 24;
    localparam int unsigned GATE_W          = 8;
    localparam logic [7:0]  GATE_FULL       = 8'hff;
    localparam logic [7:0]  GATE_OFF        = 8'h00;

    // switch sequencing states, one-hot
    typedef enum logic [3:0] {
        SW_OFF  = 4'h1,
        SW_RAMP = 4'h2,
        SW_ON   = 4'h4,
        SW_SAG  = 4'h8
    } sw_state_e;

endpackage

// *** logic/sync_filter.sv ***
// two-flop synchroniser for the comparator indications
`timescale 1ns/100ps
module sync_filter
#(
    parameter int unsigned WIDTH = 4
)
(
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;

    // second stage reads only the first
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.meta = async_in;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign sync_out = st_r.sync;

endmodule

// *** logic/load_switch_protection_ctrl.sv ***
// enable, soft start, fault timing and protection for a high-side switch
`timescale 1ns/100ps

// Overview of operation
// - switch on while enable is active
// - enable polarity chosen by build parameter
// - switch fully off while disabled
// - current limit while overcurrent indication present
// - open-drain active-low fault on limit/thermal
// - overcurrent fault reported only after qualification delay
// - plain variant: limit now, fault after 32ms
// - plain variant: fault held 32ms after clear
// - surge variant: secondary limit for 128ms window
// - surge variant: primary limit and fault after window
// - surge variant: fault held 128ms after clear
// - below lockout: switch off, pins inactive
// - sag present 32ms disables the switch
// - re-enable after 128ms, repeat on sag
// - over-temperature: switch off, fault asserted
// - cooled indication resumes switch, thermal cycling
// - gate ramps up at turn-on
module load_switch_protection_ctrl
#(
    parameter bit          EN_ACTIVE_HIGH = 1'b1,
    parameter bit          SURGE_TOLERANT = 1'b0,
    parameter bit          SAG_MONITOR    = 1'b1,
    parameter int unsigned FAULT_DLY_CYC  = load_switch_pkg::FAULT_DLY_CYC,
    parameter int unsigned SURGE_WIN_CYC  = load_switch_pkg::SURGE_WIN_CYC,
    parameter int unsigned SAG_QUAL_CYC   = load_switch_pkg::SAG_QUAL_CYC,
    parameter int unsigned SAG_RETRY_CYC  = load_switch_pkg::SAG_RETRY_CYC,
    parameter int unsigned RAMP_CYC       = load_switch_pkg::RAMP_CYC
)
(
    input  wire logic                              ref_clk,
    input  wire logic                              reset,
    input  wire logic                              enable_in,
    input  wire logic                              overcurrent_ind,
    input  wire logic                              overtemp_ind,
    input  wire logic                              low_supply_lockout,
    input  wire logic                              supply_sag_monitor,
    output logic                                   switch_on,
    output logic [load_switch_pkg::GATE_W-1:0]     gate_drive,
    output logic                                   limit_primary,
    output logic                                   limit_secondary,
    output logic                                   fault_n_out,
    output logic                                   fault_n_oe
);

    localparam int unsigned TW = load_switch_pkg::TMR_W;
    localparam logic [TW-1:0] FAULT_LAST = TW'(FAULT_DLY_CYC - 1);
    localparam logic [TW-1:0] SURGE_LAST = TW'(SURGE_WIN_CYC - 1);
    localparam logic [TW-1:0] SAGQ_LAST  = TW'(SAG_QUAL_CYC - 1);
    localparam logic [TW-1:0] SAGR_LAST  = TW'(SAG_RETRY_CYC - 1);
    localparam logic [TW-1:0] RAMP_LAST  = TW'(RAMP_CYC - 1);
    localparam logic [TW-1:0] HOLD_LAST  = SURGE_TOLERANT ? SURGE_LAST : FAULT_LAST;

    // ------------------------------------------------------------
    // synchronised indications
    // ------------------------------------------------------------
    logic [3:0] ind_sync;
    logic       oc_s;
    logic       ot_s;
    logic       uv_s;
    logic       sag_s;

    sync_filter #(.WIDTH(4)) u_sync
    (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in ({overcurrent_ind, overtemp_ind, low_supply_lockout, supply_sag_monitor}),
        .sync_out (ind_sync)
    );

    assign oc_s  = ind_sync[3];
    assign ot_s  = ind_sync[2];
    assign uv_s  = ind_sync[1];
    assign sag_s = ind_sync[0];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        load_switch_pkg::sw_state_e       sw;
        logic [TW-1:0]                    sw_tmr;     // ramp or sag retry timer
        logic [TW-1:0]                    sag_tmr;    // sag qualification
        logic [TW-1:0]                    surge_tmr;  // surge window since turn-on
        logic                             surge_done;
        logic [TW-1:0]                    q_tmr;      // fault qualify
        logic [TW-1:0]                    h_tmr;      // fault release hold
        logic                             fault;
        logic                             therm_off;
        logic                             sw_on;
        logic [load_switch_pkg::GATE_W-1:0] gate;
        logic                             lim_p;
        logic                             lim_s;
        logic                             fault_oe;
    } ctrl_s;

    ctrl_s st_r;
    ctrl_s st_nxt;

    logic en_act;
    logic run;
    logic oc_fault;

    assign en_act = EN_ACTIVE_HIGH ? enable_in : ~enable_in;

    always_comb
    begin
        st_nxt = st_r;
        run = en_act & ~uv_s;

        if (ot_s)
            st_nxt.therm_off = 1'b1;
        else
            st_nxt.therm_off = 1'b0;

        // switch sequencing
        case (st_r.sw)
            load_switch_pkg::SW_OFF:
            begin
                st_nxt.sw_tmr = '0;
                if (run && !ot_s)
                    st_nxt.sw = load_switch_pkg::SW_RAMP;
            end
            load_switch_pkg::SW_RAMP:
            begin
                st_nxt.sw_tmr = st_r.sw_tmr + 1'b1;
                if (!run || ot_s)
                    st_nxt.sw = load_switch_pkg::SW_OFF;
                else if (st_r.sw_tmr >= RAMP_LAST)
                    st_nxt.sw = load_switch_pkg::SW_ON;
            end
            load_switch_pkg::SW_ON:
            begin
                st_nxt.sw_tmr = '0;
                if (!run || ot_s)
                    st_nxt.sw = load_switch_pkg::SW_OFF;
                else if (SAG_MONITOR && sag_s && st_r.sag_tmr >= SAGQ_LAST)
                    st_nxt.sw = load_switch_pkg::SW_SAG;
            end
            load_switch_pkg::SW_SAG:
            begin
                st_nxt.sw_tmr = st_r.sw_tmr + 1'b1;
                if (!run)
                    st_nxt.sw = load_switch_pkg::SW_OFF;
                else if (st_r.sw_tmr >= SAGR_LAST)
                    st_nxt.sw = load_switch_pkg::SW_OFF;
            end
            default:
                st_nxt.sw = load_switch_pkg::SW_OFF;
        endcase

        // sag timer restarts when sag drops
        if (st_r.sw == load_switch_pkg::SW_ON && sag_s && st_r.sag_tmr < SAGQ_LAST)
            st_nxt.sag_tmr = st_r.sag_tmr + 1'b1;
        else if (!(st_r.sw == load_switch_pkg::SW_ON && sag_s))
            st_nxt.sag_tmr = '0;

        if (st_r.sw == load_switch_pkg::SW_OFF || st_r.sw == load_switch_pkg::SW_SAG)
        begin
            st_nxt.surge_tmr  = '0;
            st_nxt.surge_done = 1'b0;
        end
        else if (!st_r.surge_done)
        begin
            st_nxt.surge_tmr = st_r.surge_tmr + 1'b1;
            if (st_r.surge_tmr >= SURGE_LAST)
                st_nxt.surge_done = 1'b1;
        end

        case (st_nxt.sw)
            load_switch_pkg::SW_RAMP:
                st_nxt.gate = (st_r.gate == load_switch_pkg::GATE_FULL)
                              ? st_r.gate : st_r.gate + 1'b1;
            load_switch_pkg::SW_ON:
                st_nxt.gate = load_switch_pkg::GATE_FULL;
            default:
                st_nxt.gate = load_switch_pkg::GATE_OFF;
        endcase
        st_nxt.sw_on = (st_nxt.sw == load_switch_pkg::SW_RAMP)
                       || (st_nxt.sw == load_switch_pkg::SW_ON);

        st_nxt.lim_s = st_nxt.sw_on & oc_s & SURGE_TOLERANT & ~st_r.surge_done;
        st_nxt.lim_p = st_nxt.sw_on & oc_s & ~st_nxt.lim_s;

        // overcurrent counts only on primary limit
        oc_fault = st_r.lim_p;

        if (oc_fault && !st_r.fault)
            st_nxt.q_tmr = (st_r.q_tmr >= FAULT_LAST) ? st_r.q_tmr : st_r.q_tmr + 1'b1;
        else
            st_nxt.q_tmr = '0;

        // release hold, restart if fault returns
        if (st_r.fault && !oc_fault && !ot_s)
            st_nxt.h_tmr = st_r.h_tmr + 1'b1;
        else
            st_nxt.h_tmr = '0;

        // fault flag set wins over release
        if (ot_s || (oc_fault && st_r.q_tmr >= FAULT_LAST))
            st_nxt.fault = 1'b1;
        else if (st_r.fault && st_r.h_tmr >= HOLD_LAST)
            st_nxt.fault = 1'b0;

        if (uv_s)
        begin
            st_nxt.fault = 1'b0;
            st_nxt.q_tmr = '0;
            st_nxt.h_tmr = '0;
        end
        st_nxt.fault_oe = st_nxt.fault;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            st_r    <= '0;
            st_r.sw <= load_switch_pkg::SW_OFF;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    assign switch_on       = st_r.sw_on;
    assign gate_drive      = st_r.gate;
    assign limit_primary   = st_r.lim_p;
    assign limit_secondary = st_r.lim_s;
    // external pull-up gives the high level
    assign fault_n_out     = 1'b0;
    assign fault_n_oe      = st_r.fault_oe;

endmodule

// *** verification/load_switch_asserts.sv ***
// port checker for the load switch protection controller
`timescale 1ns/100ps
module load_switch_asserts
#(
    parameter bit          EN_ACTIVE_HIGH = 1'b1,
    parameter bit          SURGE_TOLERANT = 1'b0,
    parameter int unsigned FAULT_DLY_CYC  = 8
)
(
    input wire logic                              ref_clk,
    input wire logic                              reset,
    input wire logic                              enable_in,
    input wire logic                              overcurrent_ind,
    input wire logic                              overtemp_ind,
    input wire logic                              low_supply_lockout,
    input wire logic                              switch_on,
    input wire logic [load_switch_pkg::GATE_W-1:0] gate_drive,
    input wire logic                              limit_primary,
    input wire logic                              limit_secondary,
    input wire logic                              fault_n_out,
    input wire logic                              fault_n_oe
);
    // ----
    // run lengths of limiting and quiet, recent heat and lockout
    // ----
    logic [7:0] lim_cnt;
    logic [7:0] quiet_cnt;
    logic [4:0] hot_seen;
    logic [4:0] lock_seen;
    always_ff @(posedge ref_clk)
    begin
        lim_cnt   <= (reset || !limit_primary) ? 8'h00 : lim_cnt + {7'h00, ~&lim_cnt};
        quiet_cnt <= (reset || limit_primary || overtemp_ind) ? 8'h00
                     : quiet_cnt + {7'h00, ~&quiet_cnt};
        hot_seen  <= {hot_seen[3:0], overtemp_ind};
        lock_seen <= {lock_seen[3:0], low_supply_lockout};
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_drain_low: assert property (fault_n_oe |-> fault_n_out == 1'b0)
        else $error("fault line driven high");
    a_off_gate_zero: assert property (!switch_on |-> gate_drive == 8'h00)
        else $error("gate driven while switch off");
    a_enable_drop: assert property ((enable_in != EN_ACTIVE_HIGH) |=> !switch_on)
        else $error("switch on without enable");
    a_ramp_start: assert property ($rose(switch_on) |-> gate_drive == 8'h01)
        else $error("gate did not start at the bottom");
    a_ramp_climb: assert property (switch_on && $past(switch_on) |->
        gate_drive >= $past(gate_drive))
        else $error("gate fell during turn-on");
    a_fault_qualify: assert property ($rose(fault_n_oe) |->
        lim_cnt >= FAULT_DLY_CYC - 1 || hot_seen != 5'h00)
        else $error("fault raised before qualification");
    a_fault_hold: assert property ($fell(fault_n_oe) |->
        quiet_cnt >= FAULT_DLY_CYC - 1 || lock_seen != 5'h00)
        else $error("fault released too early");
    a_no_secondary: assert property (SURGE_TOLERANT || !limit_secondary)
        else $error("secondary limit in plain variant");
    a_hot_shutdown: assert property ((overtemp_ind && !low_supply_lockout) [*5] |->
        !switch_on && fault_n_oe)
        else $error("hot die left switch on or fault clear");
    a_lockout_off: assert property (low_supply_lockout [*5] |->
        !switch_on && !fault_n_oe)
        else $error("switch or fault active under lockout");
    a_limit_cause: assert property (limit_primary |->
        $past(overcurrent_ind, 2) || $past(overcurrent_ind, 3))
        else $error("limit without overcurrent");

    c_fault_set: cover property ($rose(fault_n_oe));
    c_fault_clr: cover property ($fell(fault_n_oe));
    c_turn_on: cover property ($rose(switch_on));
endmodule

bind load_switch_protection_ctrl load_switch_asserts
#(
    .EN_ACTIVE_HIGH(EN_ACTIVE_HIGH), .SURGE_TOLERANT(SURGE_TOLERANT),
    .FAULT_DLY_CYC(FAULT_DLY_CYC)
)
u_chk
(
    .ref_clk(ref_clk), .reset(reset), .enable_in(enable_in),
    .overcurrent_ind(overcurrent_ind), .overtemp_ind(overtemp_ind),
    .low_supply_lockout(low_supply_lockout), .switch_on(switch_on),
    .gate_drive(gate_drive), .limit_primary(limit_primary),
    .limit_secondary(limit_secondary), .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe)
);

// *** verification/host_model.sv ***
// host side model: drives enable and reads the pulled-up fault line
`timescale 1ns/100ps
module host_model
#(
    parameter bit EN_ACTIVE_HIGH = 1'b1
)
(
    input  wire logic ref_clk,
    input  wire logic want_on,
    input  wire logic fault_n_out,
    input  wire logic fault_n_oe,
    output logic      enable_in = 1'b0,
    output wire       fault_line
);
    // ----
    // pull-up line
    // ----
    assign fault_line = fault_n_oe ? fault_n_out : 1'b1;

    // enable follows the host wish off the falling edge
    always @(negedge ref_clk)
        enable_in <= want_on ~^ EN_ACTIVE_HIGH;
endmodule

// *** verification/load_switch_protection_ctrl_tb_top.sv ***
// self-checking bench for the load switch protection controller
`timescale 1ns/100ps
module load_switch_protection_ctrl_tb_top;
    localparam int unsigned FLT = 8;
    logic        ref_clk            = 1'b0;
    logic        reset              = 1'b1;
    logic        want_on            = 1'b0;
    logic        overcurrent_ind    = 1'b0;
    logic        overtemp_ind       = 1'b0;
    logic        low_supply_lockout = 1'b0;
    logic        supply_sag_monitor = 1'b0;
    logic        switch_on;
    logic        limit_primary;
    logic        limit_secondary;
    logic        fault_n_out;
    logic        fault_n_oe;
    logic [7:0]  gate_drive;
    logic        enable_in;
    wire         fault_line;
    logic [10:0] exp_q[$];
    int          fail_count      = 0;
    int          samples_checked = 0;
    int          cycles          = 0;
    event        note_ev;

    // ----
    // design and host
    // ----
    load_switch_protection_ctrl
    #(
        .FAULT_DLY_CYC(FLT), .SURGE_WIN_CYC(16), .SAG_QUAL_CYC(8), .SAG_RETRY_CYC(16),
        .RAMP_CYC(4)
    )
    uut
    (
        .ref_clk(ref_clk), .reset(reset), .enable_in(enable_in),
        .overcurrent_ind(overcurrent_ind), .overtemp_ind(overtemp_ind),
        .low_supply_lockout(low_supply_lockout), .supply_sag_monitor(supply_sag_monitor),
        .switch_on(switch_on), .gate_drive(gate_drive), .limit_primary(limit_primary),
        .limit_secondary(limit_secondary), .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe)
    );
    host_model host
    (
        .ref_clk(ref_clk), .want_on(want_on), .fault_n_out(fault_n_out),
        .fault_n_oe(fault_n_oe), .enable_in(enable_in), .fault_line(fault_line)
    );

    // clock
    initial
        forever #25 ref_clk = ~ref_clk;

    // wait falling edges, then note {fault line, switch, limit, gate}
    task automatic expect_state(input int n, input logic [10:0] exp);
        repeat (n) @(negedge ref_clk);
        exp_q.push_back(exp);
        -> note_ev;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // compare the oldest note with the ports
    always @(note_ev)
    begin
        logic [10:0] got;
        logic [10:0] want;
        got = {fault_line, switch_on, limit_primary, gate_drive};
        want = exp_q.pop_front();
        samples_checked++;
        if (got !== want)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
            fail_count++;
        end
        // plain variant never shows the secondary limit
        samples_checked++;
        if (limit_secondary !== 1'b0)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, limit_secondary, 1'b0);
            fail_count++;
        end
    end

    // cut a hang short
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            close_out();
        end
    end

    // main sequence
    initial
    begin
        int i;
        i = $urandom(32'h180e171a);
        repeat (10) @(negedge ref_clk);
        reset = 1'b0;
        want_on <= 1'b1;
        expect_state(12, 11'h6ff);
        $display("test turn-on done");
        overcurrent_ind = 1'b1;
        repeat (FLT - 3) @(negedge ref_clk);
        overcurrent_ind = 1'b0;
        expect_state(6, 11'h6ff);
        overcurrent_ind = 1'b1;
        expect_state(8, 11'h7ff);
        expect_state(8, 11'h3ff);
        overcurrent_ind = 1'b0;
        expect_state(5, 11'h2ff);
        expect_state(12, 11'h6ff);
        $display("test overcurrent done");
        overtemp_ind = 1'b1;
        expect_state(6, 11'h000);
        overtemp_ind = 1'b0;
        expect_state(24, 11'h6ff);
        $display("test thermal done");
        supply_sag_monitor = 1'b1;
        expect_state(4, 11'h6ff);
        expect_state(10, 11'h400);
        supply_sag_monitor = 1'b0;
        expect_state(6, 11'h400);
        expect_state(18, 11'h6ff);
        $display("test supply sag done");
        low_supply_lockout = 1'b1;
        overcurrent_ind = 1'b1;
        expect_state(6, 11'h400);
        low_supply_lockout = 1'b0;
        overcurrent_ind = 1'b0;
        expect_state(14, 11'h6ff);
        $display("test lockout done");
        for (i = 0; i < 8; i++)
        begin
            overcurrent_ind = 1'b1;
            repeat ($urandom_range(1, FLT - 4)) @(negedge ref_clk);
            overcurrent_ind = 1'b0;
            expect_state($urandom_range(5, 8), 11'h6ff);
        end
        $display("test random pulses done");
        want_on <= 1'b0;
        expect_state(4, 11'h400);
        $display("test turn-off done");
        @(negedge ref_clk);
        close_out();
    end
endmodule
